// file: include/lsu_pkg.sv
// Constants and types for the load/store forwarding and segment stage.
// Assumes one core clock domain shared with issue logic and data cache.
package lsu_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 128;
  localparam int CNT_W = 32;
  localparam int SEGS = 6;
  localparam int ALIAS_BITS = 12;
  localparam int LINE_OFS_W = 6;
  localparam int CHUNK_OFS_W = 2;
  localparam int CHUNKS_PER_LINE = 16;
  localparam logic [5:0] LINE_SPLIT_OFS = 6'h30;
  // Access size as log2 of bytes
  localparam logic [2:0] SZ_1 = 3'h0;
  localparam logic [2:0] SZ_4 = 3'h2;
  localparam logic [2:0] SZ_FWD_MAX = 3'h3;
  localparam logic [2:0] SZ_16 = 3'h4;
  localparam logic [4:0] SPLIT_PEN_CYC = 5'h0e;
  localparam logic [4:0] SEG_BASE_PEN_CYC = 5'h01;
  localparam logic [4:0] CHUNK_PEN_CYC = 5'h01;
  localparam logic [3:0] GAP_SLOW = 4'h9;
  localparam logic [3:0] GAP_FAST = 4'h2;
  localparam logic [3:0] GAP_NONE = 4'h1;
  typedef enum logic [2:0] {
    DATA_SEGMENT = 3'h0,
    EXTRA_SEGMENT = 3'h1,
    CODE_SEGMENT = 3'h2,
    STACK_SEGMENT = 3'h3,
    THIRD_EXTRA_SEGMENT = 3'h4,
    FOURTH_EXTRA_SEGMENT = 3'h5
  } seg_sel_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PEN = 3'h1,
    ST_RES = 3'h3,
    ST_DRAIN = 3'h2,
    ST_ACCESS = 3'h6
  } lsu_state_t;
endpackage

// file: include/fwd_if.sv
// Lookup between the stage and its forwarding comparator.
// Purely combinational; all signals in the core clock domain.
`timescale 1ns/1ns
`default_nettype none
interface fwd_if;
  logic ld_int;
  logic [31:0] ld_addr;
  logic [2:0] ld_size;
  logic st_valid;
  logic st_int;
  logic [31:0] st_addr;
  logic [2:0] st_size;
  logic hit;
  logic overlap;
  logic narrower;
  modport lsu (
    output ld_int, ld_addr, ld_size, st_valid, st_int, st_addr, st_size,
    input hit, overlap, narrower
  );
  modport unit (
    input ld_int, ld_addr, ld_size, st_valid, st_int, st_addr, st_size,
    output hit, overlap, narrower
  );
endinterface
`default_nettype wire

// file: src/fwd_unit.sv
// Forwarding comparator: pending store against the load in hand.
// Assumes the caller presents stable fields for a whole cycle.
`timescale 1ns/1ns
`default_nettype none
module fwd_unit (
  fwd_if.unit port
);
  import lsu_pkg::*;
  wire logic [12:0] st_lo;
  wire logic [12:0] ld_lo;
  wire logic [12:0] st_end;
  wire logic [12:0] ld_end;
  wire logic same_addr;
  // Only the low address bits take part, so aliases match
  assign st_lo = {1'b0, port.st_addr[ALIAS_BITS-1:0]};
  assign ld_lo = {1'b0, port.ld_addr[ALIAS_BITS-1:0]};
  assign st_end = st_lo + (13'h0001 << port.st_size);
  assign ld_end = ld_lo + (13'h0001 << port.ld_size);
  assign same_addr = st_lo == ld_lo;
  assign port.overlap = port.st_valid && (st_lo < ld_end) && (ld_lo < st_end);
  assign port.narrower = port.overlap && (port.ld_size < port.st_size)
    && (ld_lo >= st_lo) && (ld_end <= st_end);
  assign port.hit = port.st_valid && port.st_int && port.ld_int
    && (port.st_size == port.ld_size) && same_addr
    && (port.st_size <= SZ_FWD_MAX);
endmodule
`default_nettype wire

// file: src/lsu_seg_stage.sv
// Memory-access stage: forwarding, line split, chunk and segment penalties.
// Assumes the data cache answers each request pulse with one response pulse.
`timescale 1ns/1ns
`default_nettype none
module lsu_seg_stage #(
  parameter int CNT_W = lsu_pkg::CNT_W,
  parameter int DATA_W = lsu_pkg::DATA_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_is_load,
  input wire logic req_is_int,
  input wire logic [2:0] req_size,
  input wire logic [lsu_pkg::ADDR_W-1:0] req_addr,
  input wire lsu_pkg::seg_sel_t req_seg,
  input wire logic req_string_dst,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [lsu_pkg::SEGS-1:0][lsu_pkg::ADDR_W-1:0] seg_base,
  output logic issue_stall,
  output logic dc_req_valid,
  output logic dc_req_we,
  output logic [lsu_pkg::ADDR_W-1:0] dc_req_addr,
  output logic [2:0] dc_req_size,
  output logic [DATA_W-1:0] dc_req_wdata,
  input wire logic dc_resp_valid,
  input wire logic dc_hazard,
  input wire logic [DATA_W-1:0] dc_resp_data,
  output logic load_valid,
  output logic load_fwd,
  output logic [DATA_W-1:0] load_data,
  output logic [CNT_W-1:0] memory_replay_event_count
);
  import lsu_pkg::*;

  if (DATA_W < 128 || CNT_W < 1) begin : g_chk
    $error("lsu_seg_stage: DATA_W below 128 or CNT_W below 1");
  end

  fwd_if fwd ();
  fwd_unit u_fwd (.port(fwd));

  lsu_state_t st_r, st_nxt;
  logic [4:0] pen_r, pen_nxt;
  logic [3:0] gap_r;
  logic pulse;
  logic op_v_r, op_load_r, op_int_r;
  logic [ADDR_W-1:0] op_addr_r;
  logic [2:0] op_size_r;
  logic [DATA_W-1:0] op_data_r;
  logic pend_v_r, pend_int_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic [2:0] pend_size_r;
  logic [DATA_W-1:0] pend_data_r;
  logic last_v_r;
  logic [ADDR_W-1:0] last_addr_r;

  wire logic take;
  wire logic [ADDR_W-1:0] base;
  wire logic base_nz;
  wire logic base_al;
  wire logic extra34;
  wire logic fast_seg;
  wire logic [3:0] gap_w;
  wire logic [3:0] gap_nxt;
  wire logic split_w;
  wire logic chunk_w;
  wire logic [4:0] pen_w;
  wire logic resp_ok;
  wire logic resp_bad;
  wire logic res_load;
  wire logic install;
  wire logic fwd_done;
  wire logic acc_done;
  wire logic replay_inc;

  assign take = req_valid && !issue_stall;
  assign base = seg_base[req_seg];
  assign base_nz = |base;
  assign base_al = base[LINE_OFS_W-1:0] == '0;
  assign extra34 = (req_seg == THIRD_EXTRA_SEGMENT)
    || (req_seg == FOURTH_EXTRA_SEGMENT);
  assign fast_seg = (req_seg == DATA_SEGMENT) || extra34
    || (req_seg == EXTRA_SEGMENT && req_string_dst);
  // Least spacing between this operation and the next one taken
  assign gap_w = (base_nz && !base_al) ? GAP_SLOW
    : base_nz ? (fast_seg ? GAP_FAST : GAP_SLOW)
    : extra34 ? GAP_FAST : GAP_NONE;
  assign gap_nxt = take ? 4'(gap_w - GAP_NONE)
    : (gap_r != '0) ? 4'(gap_r - 4'h1) : '0;
  assign split_w = req_is_load && (req_size == SZ_16)
    && (req_addr[LINE_OFS_W-1:0] > LINE_SPLIT_OFS);
  // Chunk index is the address above the two byte bits
  assign chunk_w = (req_size < SZ_4) && last_v_r
    && (req_addr[ADDR_W-1:CHUNK_OFS_W] == last_addr_r[ADDR_W-1:CHUNK_OFS_W])
    && (req_addr[CHUNK_OFS_W-1:0] != last_addr_r[CHUNK_OFS_W-1:0]);
  assign pen_w = (split_w ? SPLIT_PEN_CYC : 5'h00)
    + (base_nz ? SEG_BASE_PEN_CYC : 5'h00)
    + (chunk_w ? CHUNK_PEN_CYC : 5'h00);
  assign resp_ok = dc_resp_valid && !dc_hazard;
  assign resp_bad = dc_resp_valid && dc_hazard;
  assign res_load = (st_r == ST_RES) && op_load_r;
  assign install = ((st_r == ST_RES) && !op_load_r && !pend_v_r)
    || ((st_r == ST_DRAIN) && resp_ok && op_v_r && !op_load_r);
  assign fwd_done = res_load && fwd.hit;
  assign acc_done = (st_r == ST_ACCESS) && resp_ok;
  assign replay_inc = resp_bad
    || (res_load && !fwd.hit && fwd.narrower);

  assign fwd.ld_int = op_int_r;
  assign fwd.ld_addr = op_addr_r;
  assign fwd.ld_size = op_size_r;
  assign fwd.st_valid = pend_v_r;
  assign fwd.st_int = pend_int_r;
  assign fwd.st_addr = pend_addr_r;
  assign fwd.st_size = pend_size_r;

  always_comb begin
    st_nxt = st_r;
    pen_nxt = pen_r;
    pulse = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (take) begin
          pen_nxt = pen_w;
          st_nxt = (pen_w != '0) ? ST_PEN : ST_RES;
        end else if (pend_v_r) begin
          st_nxt = ST_DRAIN;
          pulse = 1'b1;
        end
      end
      ST_PEN: begin
        pen_nxt = 5'(pen_r - 5'h01);
        if (pen_r == 5'h01) begin
          st_nxt = ST_RES;
        end
      end
      ST_RES: begin
        if (!op_load_r) begin
          st_nxt = pend_v_r ? ST_DRAIN : ST_IDLE;
          pulse = pend_v_r;
        end else if (fwd.hit) begin
          st_nxt = ST_IDLE;
        end else begin
          // Overlapping store must reach the cache first
          st_nxt = fwd.overlap ? ST_DRAIN : ST_ACCESS;
          pulse = 1'b1;
        end
      end
      ST_DRAIN: begin
        if (resp_bad) begin
          pulse = 1'b1;
        end else if (resp_ok) begin
          st_nxt = (op_v_r && op_load_r) ? ST_ACCESS : ST_IDLE;
          pulse = op_v_r && op_load_r;
        end
      end
      ST_ACCESS: begin
        if (resp_bad) begin
          pulse = 1'b1;
        end else if (resp_ok) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      pen_r <= '0;
      gap_r <= '0;
      issue_stall <= 1'b0;
      op_v_r <= 1'b0;
      last_v_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pen_r <= pen_nxt;
      gap_r <= gap_nxt;
      issue_stall <= (st_nxt != ST_IDLE) || (gap_nxt != '0);
      op_v_r <= take || (op_v_r && st_nxt != ST_IDLE);
      last_v_r <= last_v_r || take;
    end
  end

  always_ff @(posedge core_clk) begin
    if (take) begin
      op_load_r <= req_is_load;
      op_int_r <= req_is_int;
      op_addr_r <= req_addr;
      op_size_r <= req_size;
      op_data_r <= req_wdata;
      last_addr_r <= req_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_v_r <= 1'b0;
    end else if (install) begin
      pend_v_r <= 1'b1;
    end else if (st_r == ST_DRAIN && resp_ok) begin
      pend_v_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (install) begin
      pend_int_r <= op_int_r;
      pend_addr_r <= op_addr_r;
      pend_size_r <= op_size_r;
      pend_data_r <= op_data_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dc_req_valid <= 1'b0;
      dc_req_we <= 1'b0;
      dc_req_addr <= '0;
      dc_req_size <= SZ_1;
      dc_req_wdata <= '0;
    end else begin
      dc_req_valid <= pulse;
      if (pulse) begin
        dc_req_we <= st_nxt == ST_DRAIN;
        dc_req_addr <= (st_nxt == ST_DRAIN) ? pend_addr_r : op_addr_r;
        dc_req_size <= (st_nxt == ST_DRAIN) ? pend_size_r : op_size_r;
        dc_req_wdata <= pend_data_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_valid <= 1'b0;
      load_fwd <= 1'b0;
      load_data <= '0;
      memory_replay_event_count <= '0;
    end else begin
      load_valid <= fwd_done || acc_done;
      load_fwd <= fwd_done;
      if (fwd_done) begin
        load_data <= pend_data_r;
      end else if (acc_done) begin
        load_data <= dc_resp_data;
      end
      if (replay_inc) begin
        memory_replay_event_count <= memory_replay_event_count + 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_split_take;
    take && split_w && !base_nz && !chunk_w;
  endsequence

  chk_fwd_int_only: assert property (
    (res_load && !(op_int_r && pend_int_r)) |=> !load_fwd)
    else $error("forward given to non-integer pair");
  chk_fwd_exact_match: assert property (
    fwd_done |-> (op_size_r == pend_size_r)
      && (op_addr_r[11:0] == pend_addr_r[11:0]))
    else $error("forward with size or address mismatch");
  chk_fwd_max_eight: assert property (
    load_fwd |-> $past(pend_size_r) <= SZ_FWD_MAX)
    else $error("forward from store wider than eight bytes");
  chk_split_wait: assert property (
    seq_split_take |=> (st_r == ST_PEN)[*7] ##1 (st_r == ST_PEN)[*7]
      ##1 (st_r == ST_RES))
    else $error("line split penalty not fourteen cycles");
  chk_gap_nine_slow: assert property (
    (take && gap_w == GAP_SLOW) |=> issue_stall[*8])
    else $error("slow segment issued within nine cycles");
  chk_gap_two_fast: assert property (
    (take && extra34) |=> issue_stall)
    else $error("extra segment issued back to back");
  chk_zero_base_free: assert property (
    (take && !base_nz && !extra34 && !split_w && !chunk_w) |=>
      (st_r == ST_RES) ##1 (st_r != ST_PEN))
    else $error("zero base operation penalised");
  chk_seg_base_delay: assert property (
    (take && base_nz) |=> (st_r == ST_PEN))
    else $error("non-zero base without added delay");
  chk_stall_busy: assert property (
    (st_r != ST_IDLE) |-> issue_stall)
    else $error("issue not stalled while memory op busy");
  chk_replay_count: assert property (
    replay_inc |=> memory_replay_event_count
      == $past(memory_replay_event_count) + 1'b1)
    else $error("memory_replay_event_count not counted");
  chk_store_drains_first: assert property (
    (res_load && !fwd.hit && fwd.overlap) |=> dc_req_valid && dc_req_we)
    else $error("overlapping load read before store drained");
endmodule
`default_nettype wire

// file: verif/dcache_model.sv
// Data cache model: one response pulse per request pulse.
// Assumes one request at a time and the core clock domain only.
`timescale 1ns/1ns
`default_nettype none
module dcache_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic haz_arm,
  input wire logic dc_req_valid,
  input wire logic dc_req_we,
  input wire logic [31:0] dc_req_addr,
  input wire logic [2:0] dc_req_size,
  input wire logic [127:0] dc_req_wdata,
  output logic dc_resp_valid,
  output logic dc_hazard,
  output logic [127:0] dc_resp_data
);
  logic [7:0] mem_r [256];
  logic [127:0] wd_r;
  logic [31:0] addr_r;
  logic [2:0] size_r;
  logic [2:0] wait_r;
  logic we_r;
  logic busy_r;
  logic haz_done_r;
  always @(posedge core_clk) begin
    dc_resp_valid <= 1'b0;
    dc_hazard <= 1'b0;
    // Data is not held outside a response
    dc_resp_data <= ~dc_resp_data;
    if (!haz_arm)
      haz_done_r <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      dc_resp_data <= '0;
    end else if (dc_req_valid) begin
      busy_r <= 1'b1;
      wait_r <= slow ? 3'h4 : 3'h0;
      we_r <= dc_req_we;
      addr_r <= dc_req_addr;
      size_r <= dc_req_size;
      wd_r <= dc_req_wdata;
    end else if (busy_r && wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else if (busy_r) begin
      busy_r <= 1'b0;
      dc_resp_valid <= 1'b1;
      if (haz_arm && !haz_done_r) begin
        dc_hazard <= 1'b1;
        haz_done_r <= 1'b1;
      end else if (we_r) begin
        for (int i = 0; i < 16; i++)
          if (i < (1 << size_r))
            mem_r[8'(addr_r[7:0] + i)] <= wd_r[8*i+:8];
      end else begin
        for (int i = 0; i < 16; i++)
          dc_resp_data[8*i+:8] <= mem_r[8'(addr_r[7:0] + i)];
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/load_store_forward_segment_unit_bench.sv
// Self-checking bench for the load/store forwarding and segment stage.
// Assumes the package in include/ and the cache model in verif/.
`timescale 1ns/1ns
`default_nettype none
module load_store_forward_segment_unit_bench;
  import lsu_pkg::*;
  localparam logic [127:0] D = 128'hfedc_ba98_7654_3210_0f1e_2d3c_4b5a_6978;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_is_load = 1'b0;
  logic req_is_int = 1'b0;
  logic [2:0] req_size = 3'h0;
  logic [31:0] req_addr = 32'h0000_0000;
  seg_sel_t req_seg = DATA_SEGMENT;
  logic req_string_dst = 1'b0;
  logic [127:0] req_wdata = '0;
  logic [SEGS-1:0][ADDR_W-1:0] seg_base = '0;
  logic slow = 1'b0;
  logic haz_arm = 1'b0;
  logic issue_stall, dc_req_valid, dc_req_we, dc_resp_valid, dc_hazard;
  logic [31:0] dc_req_addr;
  logic [2:0] dc_req_size;
  logic [127:0] dc_req_wdata, dc_resp_data, load_data;
  logic load_valid, load_fwd;
  logic [31:0] memory_replay_event_count;
  logic [31:0] exp_rep = 32'h0000_0000;
  int cyc = 0;
  int num_errors = 0;
  int n_compared = 0;
  lsu_seg_stage u_dut (.core_clk(core_clk), .rst(rst),
    .req_valid(req_valid), .req_is_load(req_is_load),
    .req_is_int(req_is_int), .req_size(req_size), .req_addr(req_addr),
    .req_seg(req_seg), .req_string_dst(req_string_dst),
    .req_wdata(req_wdata), .seg_base(seg_base), .issue_stall(issue_stall),
    .dc_req_valid(dc_req_valid), .dc_req_we(dc_req_we),
    .dc_req_addr(dc_req_addr), .dc_req_size(dc_req_size),
    .dc_req_wdata(dc_req_wdata), .dc_resp_valid(dc_resp_valid),
    .dc_hazard(dc_hazard), .dc_resp_data(dc_resp_data),
    .load_valid(load_valid), .load_fwd(load_fwd), .load_data(load_data),
    .memory_replay_event_count(memory_replay_event_count));
  dcache_model u_cache (.core_clk(core_clk), .rst(rst), .slow(slow),
    .haz_arm(haz_arm), .dc_req_valid(dc_req_valid), .dc_req_we(dc_req_we),
    .dc_req_addr(dc_req_addr), .dc_req_size(dc_req_size),
    .dc_req_wdata(dc_req_wdata), .dc_resp_valid(dc_resp_valid),
    .dc_hazard(dc_hazard), .dc_resp_data(dc_resp_data));
  always #50 core_clk = ~core_clk;
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    repeat (30) @(posedge core_clk);
  endtask
  // Holds the request until the edge that takes it
  task automatic op(logic ld, logic it, logic [2:0] sz, logic [31:0] a,
                    seg_sel_t sg, logic [127:0] wd, output int t);
    int n;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_is_load <= ld;
    req_is_int <= it;
    req_size <= sz;
    req_addr <= a;
    req_seg <= sg;
    req_wdata <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (issue_stall !== 1'b0 && n < 50);
    chk("request taken", 0, issue_stall);
    t = cyc;
    req_valid <= 1'b0;
  endtask
  task automatic wait_load(input int t0, output int lat);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (load_valid !== 1'b1 && n < 60);
    chk("load_valid", 1, load_valid);
    lat = cyc - t0;
  endtask
  task automatic pair(logic [2:0] ss, logic [31:0] sa, logic li,
                      logic [2:0] ls, logic [31:0] la,
                      output logic f, output logic [127:0] d);
    int t;
    int l;
    op(1'b0, 1'b1, ss, sa, DATA_SEGMENT, D, t);
    op(1'b1, li, ls, la, DATA_SEGMENT, D, t);
    wait_load(t, l);
    f = load_fwd;
    d = load_data;
    settle();
  endtask
  task automatic ld(logic [2:0] sz, logic [31:0] a, output int l);
    int t;
    op(1'b1, 1'b0, sz, a, DATA_SEGMENT, D, t);
    wait_load(t, l);
    settle();
  endtask
  task automatic t_fwd();
    logic f;
    logic [127:0] d;
    pair(SZ_FWD_MAX, 32'h0000_0100, 1'b1, SZ_FWD_MAX, 32'h0000_0100, f, d);
    chk("fwd flag", 1, f);
    chk("fwd data", D[63:0], d[63:0]);
    pair(SZ_4, 32'h0000_1204, 1'b1, SZ_4, 32'h0000_5204, f, d);
    chk("alias fwd flag", 1, f);
  endtask
  task automatic t_nofwd();
    logic f;
    logic [127:0] d;
    pair(SZ_FWD_MAX, 32'h0000_0040, 1'b0, SZ_FWD_MAX, 32'h0000_0040, f, d);
    chk("fp fwd flag", 0, f);
    chk("fp data", D[63:0], d[63:0]);
    pair(SZ_16, 32'h0000_0060, 1'b1, SZ_16, 32'h0000_0060, f, d);
    chk("wide fwd flag", 0, f);
    chk("wide data", D, d);
    pair(SZ_4, 32'h0000_0080, 1'b1, SZ_FWD_MAX, 32'h0000_0080, f, d);
    chk("size fwd flag", 0, f);
    chk("size data", D[31:0], d[31:0]);
    pair(SZ_4, 32'h0000_0090, 1'b1, SZ_4, 32'h0000_0094, f, d);
    chk("addr fwd flag", 0, f);
    pair(SZ_4, 32'h0000_00a0, 1'b1, SZ_1, 32'h0000_00a0, f, d);
    chk("narrow fwd flag", 0, f);
    chk("narrow data", D[7:0], d[7:0]);
    exp_rep = exp_rep + 1;
    chk("replay count", exp_rep, memory_replay_event_count);
  endtask
  task automatic t_hazard();
    int t0;
    int t1;
    slow <= 1'b1;
    haz_arm <= 1'b1;
    op(1'b1, 1'b0, SZ_4, 32'h0000_00a0, DATA_SEGMENT, D, t0);
    op(1'b0, 1'b1, SZ_4, 32'h0000_00f0, DATA_SEGMENT, D, t1);
    chk("stall span", 1, t1 - t0 >= 10);
    settle();
    exp_rep = exp_rep + 1;
    chk("replay count", exp_rep, memory_replay_event_count);
    slow <= 1'b0;
    haz_arm <= 1'b0;
  endtask
  task automatic t_split();
    int l0;
    int l1;
    ld(SZ_16, 32'h0000_0030, l0);
    ld(SZ_16, 32'h0000_0031, l1);
    chk("split penalty", 14, l1 - l0);
  endtask
  task automatic t_chunk();
    int l0;
    int l1;
    int l2;
    ld(SZ_1, 32'h0000_0080, l0);
    ld(SZ_1, 32'h0000_0084, l0);
    ld(SZ_1, 32'h0000_0085, l1);
    ld(SZ_4, 32'h0000_0088, l2);
    chk("chunk penalty", 1, l1 - l0);
    chk("aligned word", l0, l2);
  endtask
  task automatic t_gap();
    seg_sel_t gs[10] = '{DATA_SEGMENT, DATA_SEGMENT, DATA_SEGMENT,
      THIRD_EXTRA_SEGMENT, EXTRA_SEGMENT, EXTRA_SEGMENT, CODE_SEGMENT,
      STACK_SEGMENT, FOURTH_EXTRA_SEGMENT, FOURTH_EXTRA_SEGMENT};
    logic [31:0] gb[10] = '{32'h0000_0000, 32'h0000_1000, 32'h0000_1004,
      32'h0000_0000, 32'h0000_1000, 32'h0000_1000, 32'h0000_1000,
      32'h0000_1000, 32'h0000_0000, 32'h0000_1000};
    logic [9:0] sd = 10'h010;
    int ge[10] = '{2, 3, 9, 2, 3, 9, 9, 9, 2, 3};
    int t0;
    int t1;
    int l;
    for (int i = 0; i < 10; i++) begin
      seg_base[gs[i]] <= gb[i];
      req_string_dst <= sd[i];
      op(1'b0, 1'b1, SZ_4, 32'h0000_00e0, gs[i], D, t0);
      op(1'b1, 1'b1, SZ_4, 32'h0000_00e0, gs[i], D, t1);
      wait_load(t1, l);
      chk("take spacing", ge[i], t1 - t0);
      seg_base <= '0;
      settle();
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    chk("replay count", 0, memory_replay_event_count);
    t_fwd();
    t_nofwd();
    t_hazard();
    t_split();
    t_chunk();
    t_gap();
    results();
  end
endmodule
`default_nettype wire
